/* poss_top.sv */
// Power-on strap sampler with APB register access
// Operation
// - Capture every strap pin level at power-on reset and drive modes from it.
// - Capture about one millisecond after internal or external reset release.
// - After capture, pins return to normal use; later levels are ignored.
// - Unpulled straps default: memory and PHY high, flash low; boot pins driven.
// - Memory strap 0 absent, 1 present; flash strap 0 absent, 1 present.
// - Flash vendor strap 0 selects vendor A, 1 selects vendor B.
// - Clock strap 0 gives 96 MHz, 1 gives 120 MHz; PHY strap 0 HSIC, 1 USB.
// - Boot 00 remaps to RAM, holds processor; 01 boots from ROM.
`timescale 1ns/1ns
module poss_top #(
    parameter int SETTLE_CYCLES = poss_pkg::SETTLE_CYC
) (
    input wire logic clk_in, // 50 MHz clock
    input wire logic rstn_in, // Async power-on reset, active low
    input wire logic ce_in, // Clock enable
    input wire logic strap_otp_present_in, // Memory-present strap pin
    input wire logic strap_serial_flash_present_in, // Flash-present strap pin
    input wire logic strap_serial_flash_vendor_in, // Flash vendor strap pin
    input wire logic strap_host_phy_select_in, // PHY select strap pin
    input wire logic strap_backplane_fast_clock_in, // Clock strap pin
    input wire logic [1:0] strap_boot_in, // Boot strap pins
    input wire logic psel_in, // APB select
    input wire logic penable_in, // APB enable
    input wire logic pwrite_in, // APB direction
    input wire logic [11:0] paddr_in, // APB address
    input wire logic [31:0] pwdata_in, // APB write data
    output logic [31:0] prdata_out, // APB read data
    output logic pready_out, // APB ready
    output logic pslverr_out, // APB error
    output logic strap_done_out, // Capture complete
    output logic pins_released_out, // Pins back to normal function
    output logic otp_present_out, // Memory present
    output logic serial_flash_present_out, // Flash present
    output logic serial_flash_vendor_b_out, // Flash command set B
    output logic usb_phy_mode_out, // 1 USB PHY, 0 HSIC
    output logic backplane_120mhz_out, // 1 120 MHz, 0 96 MHz
    output logic boot_from_rom_out, // Boot from ROM
    output logic remap_to_ram_out, // Memory remapped to RAM
    output logic cpu_hold_out, // Processor held in reset
    output logic boot_reserved_out // Reserved boot code seen
);
    localparam int CFG_W = poss_pkg::CFG_W;
    // ====================================================
    // Pin synchronisers
    logic [CFG_W-1:0] pins_raw;
    logic [CFG_W-1:0] sync1_r;
    logic [CFG_W-1:0] sync2_r;
    assign pins_raw = {strap_boot_in, strap_backplane_fast_clock_in, strap_host_phy_select_in,
                       strap_serial_flash_vendor_in, strap_serial_flash_present_in, strap_otp_present_in};
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_r <= poss_pkg::CFG_RESET;
            sync2_r <= poss_pkg::CFG_RESET;
        end else if (ce_in) begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end
    // ====================================================
    // Capture sequencer
    poss_pkg::poss_state_t state_r;
    logic [31:0] cnt_r;
    logic force_r;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= poss_pkg::POSS_WAIT;
            cnt_r <= 32'h0000_0000;
        end else if (ce_in) begin
            case (state_r)
                poss_pkg::POSS_WAIT: begin
                    if (cnt_r >= 32'(SETTLE_CYCLES - 1) || force_r) begin
                        state_r <= poss_pkg::POSS_CAPTURE;
                    end else begin
                        cnt_r <= cnt_r + 32'h0000_0001;
                    end
                end
                poss_pkg::POSS_CAPTURE: state_r <= poss_pkg::POSS_DONE;
                poss_pkg::POSS_DONE: state_r <= poss_pkg::POSS_DONE;
                default: state_r <= poss_pkg::POSS_WAIT;
            endcase
        end
    end
    // ====================================================
    // Configuration latch
    logic [CFG_W-1:0] cfg_r;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_r <= poss_pkg::CFG_RESET;
        end else if (ce_in && state_r == poss_pkg::POSS_CAPTURE) begin
            cfg_r <= sync2_r;
        end
    end
    // ====================================================
    // Decoded outputs
    logic [1:0] boot;
    assign boot = cfg_r[poss_pkg::CFG_BOOT_LSB +: 2];
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            strap_done_out <= 1'b0;
            pins_released_out <= 1'b0;
            otp_present_out <= 1'b1;
            serial_flash_present_out <= 1'b0;
            serial_flash_vendor_b_out <= 1'b0;
            usb_phy_mode_out <= 1'b1;
            backplane_120mhz_out <= 1'b1;
            boot_from_rom_out <= 1'b0;
            remap_to_ram_out <= 1'b1;
            cpu_hold_out <= 1'b1;
            boot_reserved_out <= 1'b0;
        end else if (ce_in) begin
            strap_done_out <= state_r == poss_pkg::POSS_DONE;
            pins_released_out <= state_r == poss_pkg::POSS_DONE;
            otp_present_out <= cfg_r[poss_pkg::CFG_OTP_BIT];
            serial_flash_present_out <= cfg_r[poss_pkg::CFG_SFL_BIT];
            serial_flash_vendor_b_out <= cfg_r[poss_pkg::CFG_VEND_BIT];
            usb_phy_mode_out <= cfg_r[poss_pkg::CFG_PHY_BIT];
            backplane_120mhz_out <= cfg_r[poss_pkg::CFG_CLK_BIT];
            // boot decode, processor held until done
            boot_from_rom_out <= state_r == poss_pkg::POSS_DONE && boot == poss_pkg::BOOT_ROM;
            remap_to_ram_out <= boot == poss_pkg::BOOT_RAM_HOLD;
            cpu_hold_out <= state_r != poss_pkg::POSS_DONE || boot != poss_pkg::BOOT_ROM;
            // reserved codes flagged, processor kept held
            boot_reserved_out <= state_r == poss_pkg::POSS_DONE &&
                                 boot != poss_pkg::BOOT_ROM && boot != poss_pkg::BOOT_RAM_HOLD;
        end
    end
    // ====================================================
    // APB slave, zero wait states
    logic acc;
    logic mapped;
    assign acc = psel_in && penable_in;
    assign mapped = paddr_in == poss_pkg::CTRL_OFF || paddr_in == poss_pkg::STAT_OFF ||
                    paddr_in == poss_pkg::CFG_OFF || paddr_in == poss_pkg::PINS_OFF;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            force_r <= 1'b0;
        end else if (ce_in && acc && pready_out && pwrite_in && paddr_in == poss_pkg::CTRL_OFF) begin
            // Early capture for test; ignored once captured
            force_r <= pwdata_in[0];
        end
    end
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else if (ce_in) begin
            pready_out <= psel_in && !pready_out;
            pslverr_out <= psel_in && !pready_out && !mapped;
            prdata_out <= 32'h0000_0000;
            if (psel_in && !pready_out && !pwrite_in) begin
                case (paddr_in)
                    poss_pkg::CTRL_OFF: prdata_out <= {31'h0000_0000, force_r};
                    poss_pkg::STAT_OFF: prdata_out <= {30'h0000_0000, state_r == poss_pkg::POSS_DONE,
                                                       boot_reserved_out};
                    poss_pkg::CFG_OFF: prdata_out <= {25'h000_0000, cfg_r};
                    poss_pkg::PINS_OFF: prdata_out <= {25'h000_0000, sync2_r};
                    default: prdata_out <= poss_pkg::ERR_DATA;
                endcase
            end
        end
    end
    // ====================================================
    // Checks
    a_cfg_stable_done:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        state_r == poss_pkg::POSS_DONE |=> $stable(cfg_r)) else $error("config changed after capture");
    a_pins_ignored:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        strap_done_out && $changed(sync2_r) |=> $stable(cfg_r)) else $error("pin change reached config");
    a_capture_value:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && state_r == poss_pkg::POSS_CAPTURE |=> cfg_r == $past(sync2_r)) else $error("capture wrong");
    a_capture_once:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && state_r == poss_pkg::POSS_CAPTURE |=> state_r == poss_pkg::POSS_DONE) else $error("no done");
    a_presence_map:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in |=> otp_present_out == $past(cfg_r[0]) && serial_flash_present_out == $past(cfg_r[1]))
        else $error("presence map wrong");
    a_vendor_map:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in |=> serial_flash_vendor_b_out == $past(cfg_r[2])) else $error("vendor map wrong");
    a_phy_clock_map:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in |=> usb_phy_mode_out == $past(cfg_r[3]) && backplane_120mhz_out == $past(cfg_r[4]))
        else $error("phy or clock map wrong");
    a_boot_hold:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        remap_to_ram_out |-> cpu_hold_out && !boot_from_rom_out) else $error("ram boot not held");
    a_default_pulls:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        !strap_done_out && state_r == poss_pkg::POSS_WAIT && cnt_r == 32'h0000_0001 |-> cfg_r == poss_pkg::CFG_RESET)
        else $error("reset defaults wrong");

    // ====================================================
    // Capture deadline tracker
    // Counts enabled cycles only, so a frozen enable does not eat the deadline
    logic [31:0] rel_cnt_r;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rel_cnt_r <= 32'h0000_0000;
        end else if (ce_in && !strap_done_out) begin
            rel_cnt_r <= rel_cnt_r + 32'h0000_0001;
        end
    end

    a_capture_deadline:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        rel_cnt_r <= 32'(SETTLE_CYCLES + 2)) else $error("capture too late");

    a_done_sticky:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        strap_done_out |=> strap_done_out) else $error("done dropped");

    a_release_done:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        pins_released_out == strap_done_out) else $error("release differs from done");

    a_done_state:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        strap_done_out |-> state_r == poss_pkg::POSS_DONE) else $error("done outside done state");

    a_no_early_done:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        state_r != poss_pkg::POSS_DONE |-> !strap_done_out) else $error("done too early");

    a_wait_counts:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && state_r == poss_pkg::POSS_WAIT && !force_r && cnt_r < 32'(SETTLE_CYCLES - 1) |=>
        state_r == poss_pkg::POSS_WAIT) else $error("capture before settle time");

    a_force_capture:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && state_r == poss_pkg::POSS_WAIT && force_r |=> state_r == poss_pkg::POSS_CAPTURE)
        else $error("early capture ignored");

    a_done_follows:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && state_r == poss_pkg::POSS_CAPTURE ##1 ce_in |=> strap_done_out) else $error("done late");

    a_freeze_seq:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        !ce_in |=> $stable(state_r) && $stable(cnt_r)) else $error("sequencer moved while frozen");

    a_freeze_cfg:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        !ce_in |=> $stable(cfg_r) && $stable(strap_done_out)) else $error("config moved while frozen");

    a_wait_defaults:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        state_r == poss_pkg::POSS_WAIT |-> cfg_r == poss_pkg::CFG_RESET) else $error("defaults lost");

    a_rom_boot:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        boot_from_rom_out |-> !cpu_hold_out && !remap_to_ram_out) else $error("rom boot still held");

    a_reserved_held:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        boot_reserved_out |-> cpu_hold_out && !boot_from_rom_out && !remap_to_ram_out)
        else $error("reserved boot code acted on");

    a_hold_pending:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        !strap_done_out |-> cpu_hold_out && !boot_from_rom_out && !boot_reserved_out) else $error("boot early");

    a_boot_decode:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in |=> remap_to_ram_out == ($past(cfg_r[poss_pkg::CFG_BOOT_LSB +: 2]) == poss_pkg::BOOT_RAM_HOLD))
        else $error("remap decode wrong");

    a_outs_settled:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        strap_done_out |=> $stable(otp_present_out) && $stable(serial_flash_present_out) &&
        $stable(serial_flash_vendor_b_out) && $stable(usb_phy_mode_out) && $stable(backplane_120mhz_out))
        else $error("mode output moved after capture");

    a_boot_settled:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        strap_done_out |=> $stable(boot_from_rom_out) && $stable(remap_to_ram_out) && $stable(cpu_hold_out) &&
        $stable(boot_reserved_out)) else $error("boot output moved after capture");

    a_presence_done:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        strap_done_out |-> otp_present_out == cfg_r[poss_pkg::CFG_OTP_BIT] &&
        serial_flash_present_out == cfg_r[poss_pkg::CFG_SFL_BIT]) else $error("presence differs from latch");

    a_vendor_done:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        strap_done_out |-> serial_flash_vendor_b_out == cfg_r[poss_pkg::CFG_VEND_BIT]) else $error("vendor differs");

    a_modes_done:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        strap_done_out |-> usb_phy_mode_out == cfg_r[poss_pkg::CFG_PHY_BIT] &&
        backplane_120mhz_out == cfg_r[poss_pkg::CFG_CLK_BIT]) else $error("phy or clock differs");

    a_sync_first:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in |=> sync1_r == $past(pins_raw)) else $error("first sync stage wrong");

    a_sync_second:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in |=> sync2_r == $past(sync1_r)) else $error("second sync stage wrong");

    a_cfg_read:
    assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && psel_in && !pwrite_in && !pready_out && paddr_in == poss_pkg::CFG_OFF |=>
        prdata_out == {25'h000_0000, $past(cfg_r)}) else $error("config read wrong");
endmodule

/* poss_pkg.sv */
// Package with constants for the power-on strap sampler
package poss_pkg;
    // Register byte offsets
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STAT_OFF = 12'h004;
    localparam logic [11:0] CFG_OFF = 12'h008;
    localparam logic [11:0] PINS_OFF = 12'h00C;
    // Captured configuration field positions
    localparam int CFG_OTP_BIT = 0;
    localparam int CFG_SFL_BIT = 1;
    localparam int CFG_VEND_BIT = 2;
    localparam int CFG_PHY_BIT = 3;
    localparam int CFG_CLK_BIT = 4;
    localparam int CFG_BOOT_LSB = 5;
    localparam int CFG_W = 7;
    // Values after reset: pull defaults, boot reads as remap-to-RAM
    localparam logic [6:0] CFG_RESET = 7'h19;
    // Boot encodings
    localparam logic [1:0] BOOT_RAM_HOLD = 2'h0;
    localparam logic [1:0] BOOT_ROM = 2'h1;
    // Timing: settle time before capture, in microseconds
    localparam int SETTLE_US = 1000;
    localparam int CLK_MHZ = 50;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam logic [31:0] ERR_DATA = 32'hDEAD_0000;
    typedef enum logic [1:0] {
        POSS_WAIT,
        POSS_CAPTURE,
        POSS_DONE
    } poss_state_t;
endpackage

/* poss_board.sv */
// Board strap resistor model for the strap sampler
`timescale 1ns/1ns
module poss_board (
    input wire logic clk_in, // Clock for floating pattern
    input wire logic [4:0] ext_en_in, // External resistor fitted
    input wire logic [4:0] ext_val_in, // Level of that resistor
    input wire logic boot_en_in, // Boot pins driven
    input wire logic [1:0] boot_val_in, // Boot drive level
    output logic [4:0] strap_out, // {clk,phy,vend,flash,otp}
    output logic [1:0] boot_out // Boot pin levels
);
    logic [1:0] float_r = 2'h1;
    assign strap_out = (ext_en_in & ext_val_in) | (~ext_en_in & 5'h19);
    // boot pins unpulled; undriven level keeps changing
    always_ff @(posedge clk_in) begin
        float_r <= ~float_r;
    end
    assign boot_out = boot_en_in ? boot_val_in : float_r;
endmodule

/* tb_top.sv */
// Self-checking bench for the strap sampler
`timescale 1ns/1ns
module tb_top;
    logic clk_in = 0;
    logic rstn_in = 0;
    logic psel = 0;
    logic pen = 0;
    logic pwr = 0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0000_0000;
    logic [4:0] en = 5'h00;
    logic [4:0] val = 5'h00;
    logic ben = 1;
    logic [1:0] bval = 2'h0;
    logic ce = 1;
    localparam int SETTLE = 20;
    wire [4:0] sp;
    wire [1:0] bp;
    wire [31:0] prdata;
    wire pready, pslverr, done, rel;
    wire [8:0] dec;
    int bad_count = 0;
    int comparisons = 0;
    always #10 clk_in = ~clk_in;
    poss_board i_poss_board (.clk_in(clk_in), .ext_en_in(en), .ext_val_in(val), .boot_en_in(ben),
        .boot_val_in(bval), .strap_out(sp), .boot_out(bp));
    poss_top #(.SETTLE_CYCLES(SETTLE)) i_poss_top (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
        .strap_otp_present_in(sp[0]), .strap_serial_flash_present_in(sp[1]),
        .strap_serial_flash_vendor_in(sp[2]), .strap_host_phy_select_in(sp[3]),
        .strap_backplane_fast_clock_in(sp[4]), .strap_boot_in(bp), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .strap_done_out(done), .pins_released_out(rel), .otp_present_out(dec[0]),
        .serial_flash_present_out(dec[1]), .serial_flash_vendor_b_out(dec[2]), .usb_phy_mode_out(dec[3]),
        .backplane_120mhz_out(dec[4]), .boot_from_rom_out(dec[5]), .remap_to_ram_out(dec[6]),
        .cpu_hold_out(dec[7]), .boot_reserved_out(dec[8]));
    task automatic final_report;
        $display("counts: %0d compares, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_in);
        pen <= 1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        pen <= 0;
        @(posedge clk_in);
    endtask
    // Decoded outputs {rsv,hold,remap,rom,clk,phy,vend,flash,otp}
    function automatic logic [8:0] exp_dec(input logic [6:0] c);
        return {c[6], c[6:5] != 2'h1, c[6:5] == 2'h0, c[6:5] == 2'h1, c[4:0]};
    endfunction
    initial begin
        logic [31:0] q;
        logic e;
        logic [6:0] c;
        int n;
        void'($urandom(57191));
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_in);
            rstn_in <= 0;
            en <= (i == 0) ? 5'h00 : 5'($urandom);
            val <= 5'($urandom);
            ben <= 1;
            bval <= 2'(i);
            repeat (12) @(posedge clk_in);
            chk("reset outputs", {done, rel, dec}, 11'h0D9);
            c = {bval, sp};
            rstn_in <= 1;
            if (i[2]) begin
                apb(1, poss_pkg::CTRL_OFF, 32'h0000_0001, q, e);
            end else if (i[1]) begin
                ce <= 0;
                repeat (5) @(posedge clk_in);
                ce <= 1;
            end
            n = 0;
            while (done !== 1'b1 && n < 40) begin
                @(posedge clk_in);
                n++;
            end
            chk("capture time", n, i[2] ? 3 : SETTLE + 3);
            @(negedge clk_in);
            chk("decoded", {rel, dec}, {1'b1, exp_dec(c)});
            apb(0, poss_pkg::CFG_OFF, 0, q, e);
            chk("cfg reg", q, {25'h0, c});
            chk("cfg err", e, 0);
            apb(0, poss_pkg::CTRL_OFF, 0, q, e);
            chk("ctrl reg", q, {31'h0, i[2]});
            apb(0, poss_pkg::STAT_OFF, 0, q, e);
            chk("stat reg", q, {30'h0, 1'b1, c[6]});
            apb(0, 12'h010, 0, q, e);
            chk("unmapped err", e, 1);
            chk("unmapped data", q, poss_pkg::ERR_DATA);
            en <= 5'h1F;
            val <= ~c[4:0];
            ben <= 0;
            repeat (10) @(posedge clk_in);
            @(negedge clk_in);
            chk("after capture", {rel, dec}, {1'b1, exp_dec(c)});
            apb(0, poss_pkg::PINS_OFF, 0, q, e);
            chk("pins reg", q[4:0], 5'(~c[4:0]));
            $display("test %0d done", i);
        end
        final_report();
    end
    initial begin
        #400000;
        bad_count++;
        final_report();
    end
endmodule
